/* File: aux_timer_pair_counter_map.vh */
`ifndef AUX_TIMER_PAIR_COUNTER_MAP_VH
`define AUX_TIMER_PAIR_COUNTER_MAP_VH

`define ATP_ADDR_CTRL_A   16'hFF40
`define ATP_ADDR_CTRL_B   16'hFF44
`define ATP_ADDR_CNT_A    16'hFF48
`define ATP_ADDR_CNT_B    16'hFF4C
`define ATP_ADDR_STATUS   16'hFF50
`define ATP_ADDR_MASK     16'hFF54

`define ATP_CTRL_RESET    9'h000
`define ATP_CNT_RESET     16'h0000
`define ATP_SEL_LSB       0
`define ATP_SEL_MSB       2
`define ATP_MODE_LSB      3
`define ATP_MODE_MSB      5
`define ATP_RUN_BIT       6
`define ATP_UD_BIT        7
`define ATP_UDE_BIT       8

`define ATP_MODE_TIMER    3'h0
`define ATP_MODE_COUNTER  3'h1
`define ATP_MODE_GATE_LO  3'h2
`define ATP_MODE_GATE_HI  3'h3
`define ATP_MODE_RELOAD   3'h4
`define ATP_MODE_CAPTURE  3'h5
`define ATP_MODE_INCR     3'h6
`define ATP_MODE_RSVD     3'h7

`define ATP_PSC_BASE      11'h008
`define ATP_CNT_MAX       16'hFFFF
`define ATP_CNT_MIN       16'h0000

`endif

/* File: aux_timer_pair_counter.v */
`timescale 1ns/1ps
`include "aux_timer_pair_counter_map.vh"

module atp_aux_timer_pair_counter (
  input  wire        sys_clk_i,
  input  wire        reset_n_i,
  input  wire        clk_en_i,
  input  wire [15:0] avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  input  wire [1:0]  count_input_pin_i,
  input  wire [1:0]  count_dir_pin_i,
  input  wire        core_output_toggle_latch_i,
  input  wire        core_overflow_i,
  input  wire [15:0] core_timer_value_i,
  output reg         reload_strobe_o,
  output reg  [15:0] reload_value_o,
  output reg         irq_o
);

  // Byte lanes three and two carry nothing; every register fits in the low half-word.
  function [15:0] byte_merge;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0]  be;
    begin
      byte_merge = {(be[1] ? new_val[15:8] : old_val[15:8]),
                    (be[0] ? new_val[7:0]  : old_val[7:0])};
    end
  endfunction

  // Bus handshake.
  wire        bus_req;
  wire        bus_fire;
  wire        wr_fire;
  reg  [31:0] rd_next;

  assign bus_req  = avs_read_i | avs_write_i;
  // Writes land only at the edge that completes the access, never in the wait cycle.
  assign bus_fire = clk_en_i & bus_req & ~avs_waitrequest_o;
  assign wr_fire  = bus_fire & avs_write_i;

  // Shared prescaler base; each channel taps its own division ratio.
  // A timer started mid-period sees its first tick early, by up to one prescaler period.
  reg  [9:0]  psc_reg;
  wire [9:0]  psc_next;

  assign psc_next = psc_reg + 10'h001;

  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      psc_reg <= 10'h000;
    end else if (clk_en_i) begin
      psc_reg <= psc_next;
    end
  end

  // Core toggle latch seen on the same clock: no synchroniser needed.
  reg         otl_d_reg;
  reg         ovf_d_reg;
  wire        otl_rise;
  wire        otl_fall;

  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      otl_d_reg <= 1'b0;
      ovf_d_reg <= 1'b0;
    end else if (clk_en_i) begin
      otl_d_reg <= core_output_toggle_latch_i;
      ovf_d_reg <= core_overflow_i;
    end
  end

  // A latch change counts only in the cycle after a core overflow, so software writes are ignored.
  assign otl_rise = ovf_d_reg & core_output_toggle_latch_i & ~otl_d_reg;
  assign otl_fall = ovf_d_reg & ~core_output_toggle_latch_i & otl_d_reg;

  wire [17:0] ctrl_w;
  wire [31:0] cnt_w;
  wire [1:0]  evt_w;
  wire [1:0]  trig_w;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      localparam [15:0] CTRL_ADDR = (g == 0) ? `ATP_ADDR_CTRL_A : `ATP_ADDR_CTRL_B;
      localparam [15:0] CNT_ADDR  = (g == 0) ? `ATP_ADDR_CNT_A  : `ATP_ADDR_CNT_B;

      reg  [8:0]  ctrl_reg;
      reg  [15:0] cnt_reg;
      reg  [15:0] cnt_next;
      reg  [1:0]  sync1_reg;
      reg  [1:0]  sync2_reg;
      reg  [1:0]  sync3_reg;
      reg  [1:0]  flt_reg;
      wire [1:0]  flt_next;
      wire [1:0]  agree;
      wire [2:0]  sel;
      wire [2:0]  mode;
      wire        run;
      wire        count_down;
      wire [10:0] psc_mask;
      wire        tick;
      wire        pin_lvl;
      wire        pin_rise;
      wire        pin_fall;
      wire        src_rise;
      wire        src_fall;
      wire        edge_hit;
      wire        cap_hit;
      reg         adv;
      reg         ovf;
      reg         trig;
      reg         capt;
      wire [15:0] ctrl_wr;

      // Bit 0 is the count/gate pin, bit 1 the external direction pin.
      always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          sync1_reg <= 2'h0;
          sync2_reg <= 2'h0;
          sync3_reg <= 2'h0;
          flt_reg   <= 2'h0;
        end else if (clk_en_i) begin
          sync1_reg <= {count_dir_pin_i[g], count_input_pin_i[g]};
          sync2_reg <= sync1_reg;
          sync3_reg <= sync2_reg;
          flt_reg   <= flt_next;
        end
      end

      // Pin edges act four clocks after the pin moves; pulses shorter than two clocks are lost.
      // A level is accepted once the second and third stages agree.
      assign agree    = ~(sync2_reg ^ sync3_reg);
      assign flt_next = (sync3_reg & agree) | (flt_reg & ~agree);
      assign pin_lvl  = flt_reg[0];
      assign pin_rise = flt_next[0] & ~flt_reg[0];
      assign pin_fall = ~flt_next[0] & flt_reg[0];

      assign sel        = ctrl_reg[`ATP_SEL_MSB:`ATP_SEL_LSB];
      assign mode       = ctrl_reg[`ATP_MODE_MSB:`ATP_MODE_LSB];
      assign run        = ctrl_reg[`ATP_RUN_BIT];
      // Pin high with external direction enabled inverts the programmed direction.
      assign count_down = ctrl_reg[`ATP_UD_BIT] ^ (ctrl_reg[`ATP_UDE_BIT] & flt_reg[1]);

      assign psc_mask = (`ATP_PSC_BASE << sel) - 11'h001;
      assign tick     = ((psc_reg & psc_mask[9:0]) == psc_mask[9:0]);

      assign src_rise = sel[2] ? otl_rise : pin_rise;
      assign src_fall = sel[2] ? otl_fall : pin_fall;
      assign edge_hit = (sel[0] & src_rise) | (sel[1] & src_fall);
      assign cap_hit  = (sel[0] & pin_rise) | (sel[1] & pin_fall);

      // Bits above the direction enable are not stored and read back as zero.
      assign ctrl_wr  = byte_merge({7'h00, ctrl_reg}, avs_writedata_i[15:0], avs_byteenable_i[1:0]);

      always @* begin
        adv  = 1'b0;
        trig = 1'b0;
        capt = 1'b0;
        case (mode)
          `ATP_MODE_TIMER: begin
            adv = run & tick;
          end
          `ATP_MODE_COUNTER: begin
            adv = run & edge_hit;
          end
          `ATP_MODE_GATE_LO: begin
            adv = run & tick & ~pin_lvl;
          end
          `ATP_MODE_GATE_HI: begin
            adv = run & tick & pin_lvl;
          end
          `ATP_MODE_RELOAD: begin
            trig = edge_hit;
          end
          `ATP_MODE_CAPTURE: begin
            capt = cap_hit;
          end
          // Incremental and reserved modes hold the count and raise nothing.
          default: begin
            adv = 1'b0;
          end
        endcase
      end

      // A software write to the count wins over a capture or a count in the same cycle.
      always @* begin
        ovf      = 1'b0;
        cnt_next = cnt_reg;
        if (wr_fire && avs_address_i == CNT_ADDR) begin
          cnt_next = byte_merge(cnt_reg, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
        end else if (capt) begin
          cnt_next = core_timer_value_i;
        end else if (adv) begin
          if (count_down) begin
            cnt_next = cnt_reg - 16'h0001;
            ovf      = (cnt_reg == `ATP_CNT_MIN);
          end else begin
            cnt_next = cnt_reg + 16'h0001;
            ovf      = (cnt_reg == `ATP_CNT_MAX);
          end
        end
      end

      always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          ctrl_reg <= `ATP_CTRL_RESET;
          cnt_reg  <= `ATP_CNT_RESET;
        end else if (clk_en_i) begin
          if (wr_fire && avs_address_i == CTRL_ADDR) begin
            ctrl_reg <= ctrl_wr[8:0];
          end
          cnt_reg <= cnt_next;
        end
      end

      assign ctrl_w[g*9 +: 9]   = ctrl_reg;
      assign cnt_w[g*16 +: 16]  = cnt_reg;
      assign evt_w[g]           = ovf | trig | capt;
      assign trig_w[g]          = trig;
    end
  endgenerate

  // Interrupt status and mask.
  reg  [1:0]  status_reg;
  reg  [1:0]  mask_reg;
  wire [1:0]  status_clr;
  wire [1:0]  status_next;

  // Only byte lane zero can clear flags.
  assign status_clr  = (wr_fire && avs_address_i == `ATP_ADDR_STATUS && avs_byteenable_i[0]) ?
                       avs_writedata_i[1:0] : 2'h0;
  // A new event beats a simultaneous write-one-to-clear.
  assign status_next = (status_reg & ~status_clr) | evt_w;

  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_reg <= 2'h0;
    end else if (clk_en_i) begin
      status_reg <= status_next;
    end
  end

  // Masking gates only the request line; status bits still set while masked.
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_reg <= 2'h0;
    end else if (clk_en_i) begin
      if (wr_fire && avs_address_i == `ATP_ADDR_MASK && avs_byteenable_i[0]) begin
        mask_reg <= avs_writedata_i[1:0];
      end
    end
  end

  // The request follows a new status at once but a new mask one cycle later.
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_o <= |(status_next & mask_reg);
    end
  end

  // Reload toward the core timer is the only output on the core side; no toggle latch is kept.
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reload_strobe_o <= 1'b0;
    end else if (clk_en_i) begin
      reload_strobe_o <= |trig_w;
    end
  end

  // Timer B wins if both fire together; the value holds between strobes.
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reload_value_o <= 16'h0000;
    end else if (clk_en_i) begin
      if (trig_w[1]) begin
        reload_value_o <= cnt_w[31:16];
      end else if (trig_w[0]) begin
        reload_value_o <= cnt_w[15:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero.
  always @* begin
    rd_next = 32'h00000000;
    case (avs_address_i)
      `ATP_ADDR_CTRL_A: begin
        rd_next = {23'h000000, ctrl_w[8:0]};
      end
      `ATP_ADDR_CTRL_B: begin
        rd_next = {23'h000000, ctrl_w[17:9]};
      end
      `ATP_ADDR_CNT_A: begin
        rd_next = {16'h0000, cnt_w[15:0]};
      end
      `ATP_ADDR_CNT_B: begin
        rd_next = {16'h0000, cnt_w[31:16]};
      end
      `ATP_ADDR_STATUS: begin
        rd_next = {30'h00000000, status_reg};
      end
      `ATP_ADDR_MASK: begin
        rd_next = {30'h00000000, mask_reg};
      end
      default: begin
        rd_next = 32'h00000000;
      end
    endcase
  end

  // Each access waits one cycle so read data is registered before the completing edge.
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (clk_en_i) begin
      if (bus_req && avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
      end else begin
        avs_waitrequest_o <= 1'b1;
      end
    end
  end

  // Read data is loaded in the wait cycle and then holds until the next access.
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (clk_en_i) begin
      if (bus_req && avs_waitrequest_o) begin
        avs_readdata_o <= rd_next;
      end
    end
  end

endmodule // atp_aux_timer_pair_counter

/* File: atp_core_pins_model.sv */
`timescale 1ns/1ps
module atp_core_pins_model (
  input  wire        clk_i,
  output reg  [1:0]  pin_o = 2'b00,
  output reg  [1:0]  dir_o = 2'b00,
  output reg         otl_o = 1'b0,
  output reg         ovf_o = 1'b0,
  output reg  [15:0] cval_o = 16'h0000
);
  // Each level is held ten clocks so no edge falls below the filter's reach.
  task set_pin(input integer k, input lvl);
    begin
      @(posedge clk_i);
      pin_o[k] <= lvl;
      repeat (10) @(posedge clk_i);
    end
  endtask
  task ovf_tgl;
    begin
      @(posedge clk_i);
      ovf_o <= 1'b1;
      @(posedge clk_i);
      ovf_o <= 1'b0;
      otl_o <= ~otl_o;
      repeat (10) @(posedge clk_i);
    end
  endtask
  task sw_tgl;
    begin
      @(posedge clk_i);
      otl_o <= ~otl_o;
      repeat (10) @(posedge clk_i);
    end
  endtask
  task set_cval(input [15:0] v);
    begin
      @(posedge clk_i);
      cval_o <= v;
    end
  endtask
endmodule // atp_core_pins_model

/* File: atp_checker.sv */
`timescale 1ns/1ps
`include "aux_timer_pair_counter_map.vh"
module atp_checker (
  input wire        sys_clk_i,
  input wire        reset_n_i,
  input wire        clk_en_i,
  input wire [15:0] avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire is_ctl = avs_address_i == `ATP_ADDR_CTRL_A || avs_address_i == `ATP_ADDR_CTRL_B;
  wire is_map = is_ctl || avs_address_i == `ATP_ADDR_CNT_A || avs_address_i == `ATP_ADDR_CNT_B
               || avs_address_i == `ATP_ADDR_STATUS || avs_address_i == `ATP_ADDR_MASK;
  sequence s_take; (avs_read_i || avs_write_i) && avs_waitrequest_o && clk_en_i; endsequence
  sequence s_done; !avs_waitrequest_o; endsequence
  sequence s_mask_off;
    !avs_waitrequest_o && clk_en_i && avs_write_i && avs_address_i == `ATP_ADDR_MASK
    && avs_byteenable_i[0] && avs_writedata_i[1:0] == 2'b00;
  endsequence
  property p_answer; s_take |=> s_done; endproperty
  property p_one; s_done ##0 clk_en_i |=> avs_waitrequest_o; endproperty
  property p_cause; s_done |-> $past(avs_read_i || avs_write_i); endproperty
  property p_upper; s_done |-> avs_readdata_o[31:16] == 16'h0000; endproperty
  property p_unmap; s_done ##0 (avs_read_i && !is_map) |-> avs_readdata_o == 32'h00000000; endproperty
  property p_ctl; s_done ##0 (avs_read_i && is_ctl) |-> avs_readdata_o[15:9] == 7'h00; endproperty
  property p_stall;
    !clk_en_i |=> $stable(avs_waitrequest_o) && $stable(avs_readdata_o) && $stable(irq_o);
  endproperty
  property p_mask_off; s_mask_off ##1 clk_en_i |=> !irq_o; endproperty
  a_answer: assert property (p_answer) else $error("no answer one cycle after request");
  a_one: assert property (p_one) else $error("waitrequest low longer than one cycle");
  a_cause: assert property (p_cause) else $error("answer without request");
  a_upper: assert property (p_upper) else $error("upper read data not zero");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_ctl: assert property (p_ctl) else $error("control upper bits not zero");
  a_stall: assert property (p_stall) else $error("outputs moved while disabled");
  a_mask_off: assert property (p_mask_off) else $error("irq high with mask cleared");
endmodule // atp_checker
bind atp_aux_timer_pair_counter atp_checker u_chk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .clk_en_i(clk_en_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));

/* File: atp_aux_timer_pair_counter_tb.sv */
`timescale 1ns/1ps
`include "aux_timer_pair_counter_map.vh"
module atp_aux_timer_pair_counter_tb;
  reg         sys_clk_i = 1'b0;
  reg         reset_n_i = 1'b0;
  reg         clk_en_i  = 1'b1;
  reg  [15:0] adr       = 16'h0000;
  reg         rd        = 1'b0;
  reg         wr        = 1'b0;
  reg  [31:0] wd        = 32'h00000000;
  reg  [31:0] d0, d1;
  wire [31:0] rdat;
  wire [15:0] cval, rval;
  wire [1:0]  pin, dir;
  wire        wt, irq, otl, ovf, rstb;
  reg  [15:0] rl_val    = 16'h0000;
  integer     err_total = 0, samples_checked = 0, cyc = 0, i, n_rl = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  atp_core_pins_model pins (.clk_i(sys_clk_i), .pin_o(pin), .dir_o(dir), .otl_o(otl), .ovf_o(ovf), .cval_o(cval));
  atp_aux_timer_pair_counter dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .count_input_pin_i(pin), .count_dir_pin_i(dir),
    .core_output_toggle_latch_i(otl), .core_overflow_i(ovf), .core_timer_value_i(cval),
    .reload_strobe_o(rstb), .reload_value_o(rval), .irq_o(irq));
  task results;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      results;
    end
  end
  // The reload strobe stands one cycle; count it and keep the value seen with it.
  always @(posedge sys_clk_i) begin
    if (rstb === 1'b1) begin
      n_rl <= n_rl + 1;
      rl_val <= rval;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Waitrequest is sampled at the rising edge; read data is taken and the request released at that edge.
  task xfer(input [15:0] a, input w, input [31:0] v, output [31:0] d);
    begin
      @(posedge sys_clk_i);
      adr <= a; wd <= v; rd <= !w; wr <= w;
      @(posedge sys_clk_i);
      while (wt !== 1'b0) @(posedge sys_clk_i);
      d = rdat;
      rd <= 1'b0; wr <= 1'b0;
    end
  endtask
  task wr_r(input [15:0] a, input [31:0] v); xfer(a, 1'b1, v, d0); endtask
  task rd_c(input [15:0] a, input [31:0] e); begin xfer(a, 1'b0, 32'h0, d1); chk(d1, e); end endtask
  initial begin
    repeat (20) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    rd_c(`ATP_ADDR_CTRL_A, 32'h0);
    rd_c(`ATP_ADDR_CTRL_B, 32'h0);
    wr_r(`ATP_ADDR_CTRL_B, 32'h0000FFFF);
    rd_c(`ATP_ADDR_CTRL_B, 32'h000001FF);
    wr_r(16'hFF60, 32'h00001234);
    rd_c(16'hFF60, 32'h0);
    clk_en_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    clk_en_i <= 1'b1;
    $display("test registers done");
    for (i = 0; i < 5; i = i + 1) begin
      wr_r(`ATP_ADDR_CNT_A, 32'h0);
      wr_r(`ATP_ADDR_CTRL_A, (i == 4) ? 32'h0000000B : 32'h00000048 + (i % 4) + 1);
      pins.set_pin(0, 1'b1);
      pins.set_pin(0, 1'b0);
      rd_c(`ATP_ADDR_CNT_A, (i == 2) ? 32'h2 : (i > 2) ? 32'h0 : 32'h1);
    end
    for (i = 0; i < 3; i = i + 1) begin
      wr_r(`ATP_ADDR_CNT_B, 32'h0);
      wr_r(`ATP_ADDR_CTRL_B, 32'h0000004D + i);
      pins.ovf_tgl; pins.ovf_tgl; pins.sw_tgl; pins.sw_tgl;
      rd_c(`ATP_ADDR_CNT_B, (i == 2) ? 32'h2 : 32'h1);
    end
    $display("test counter done");
    wr_r(`ATP_ADDR_MASK, 32'h1);
    wr_r(`ATP_ADDR_CNT_A, 32'h0);
    wr_r(`ATP_ADDR_CTRL_A, 32'h000000C9);
    pins.set_pin(0, 1'b1);
    pins.set_pin(0, 1'b0);
    rd_c(`ATP_ADDR_CNT_A, 32'h0000FFFF);
    rd_c(`ATP_ADDR_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr_r(`ATP_ADDR_MASK, 32'h0);
    rd_c(`ATP_ADDR_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr_r(`ATP_ADDR_STATUS, 32'h1);
    rd_c(`ATP_ADDR_STATUS, 32'h0);
    $display("test underflow done");
    pins.set_pin(0, 1'b1);
    for (i = 0; i < 5; i = i + 1) begin
      wr_r(`ATP_ADDR_CNT_A, 32'h0);
      wr_r(`ATP_ADDR_CTRL_A, (i == 0) ? 32'h41 : (i == 1) ? 32'h50 : (i == 2) ? 32'h58 : (i == 3) ? 32'h78 : 32'h70);
      xfer(`ATP_ADDR_CNT_A, 1'b0, 32'h0, d0);
      repeat (797) @(posedge sys_clk_i);
      xfer(`ATP_ADDR_CNT_A, 1'b0, 32'h0, d1);
      chk(d1 - d0, (i == 0) ? 32'd50 : (i == 2) ? 32'd100 : 32'd0);
    end
    $display("test timer done");
    wr_r(`ATP_ADDR_CNT_A, 32'h00001234);
    wr_r(`ATP_ADDR_CTRL_A, 32'h00000022);
    pins.set_pin(0, 1'b0);
    chk(n_rl, 32'h1);
    chk({16'h0, rl_val}, 32'h00001234);
    rd_c(`ATP_ADDR_CNT_A, 32'h00001234);
    wr_r(`ATP_ADDR_STATUS, 32'h1);
    wr_r(`ATP_ADDR_CTRL_A, 32'h00000029);
    pins.set_cval(16'hA5C3);
    pins.set_pin(0, 1'b1);
    rd_c(`ATP_ADDR_CNT_A, 32'h0000A5C3);
    rd_c(`ATP_ADDR_STATUS, 32'h1);
    chk(n_rl, 32'h1);
    $display("test reload capture done");
    results;
  end
endmodule // atp_aux_timer_pair_counter_tb
